// *** logic/stc_pkg.sv ***
// Constants shared by the sixteen-bit timer/counter block.
// Assumes a single pclk domain; all offsets are APB byte addresses.
package stc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFF_FLAG = 8'h08;
    localparam logic [7:0] OFF_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    // Control field positions
    localparam int BIT_RUN = 0;
    localparam int BIT_CLK_SRC = 1;
    localparam int BIT_SYNC_BYPASS = 2;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PS_HI = 5;
    localparam int CTRL_W = 6;
    // Flag and enable registers share one layout
    localparam int BIT_OVF = 0;
    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [2:0] DIV_RST = 3'h0;
    // Slave answers after one wait state
    localparam int WAIT_STATES = 1;
endpackage

// *** logic/stc_ps_if.sv ***
// Carrier between the timer core and its input prescaler.
// Assumes both ends run on the same pclk.
interface stc_ps_if;
    logic tick_in;
    logic [1:0] ratio;
    logic tick_out;
    modport pre (input tick_in, input ratio, output tick_out);
    modport core (output tick_in, output ratio, input tick_out);
endinterface

// *** logic/stc_sync2.sv ***
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to pclk; only stage two is read outside.
module stc_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// *** logic/stc_prescaler.sv ***
// Input prescaler: divides input ticks by 1, 2, 4 or 8.
// Assumes tick_in is a one-cycle pulse on pclk; output is combinational.
module stc_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    stc_ps_if.pre ps
);
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;

    function automatic logic [2:0] ratio_mask(input logic [1:0] sel);
        case (sel)
            2'h0: ratio_mask = 3'h0;
            2'h1: ratio_mask = 3'h1;
            2'h2: ratio_mask = 3'h3;
            default: ratio_mask = 3'h7;
        endcase
    endfunction

    // Keeps dividing pin ticks whatever the sleep state; only the later stage stops
    always_comb begin
        next_div_cnt = div_cnt;
        if (ps.tick_in) begin
            next_div_cnt = div_cnt + 3'h1;
        end
        ps.tick_out = ps.tick_in &&
            ((div_cnt & ratio_mask(ps.ratio)) == ratio_mask(ps.ratio));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= stc_pkg::DIV_RST;
        end else if (ce) begin
            div_cnt <= next_div_cnt;
        end
    end
endmodule

// *** logic/stc_timer.sv ***
// Sixteen-bit timer/counter with APB registers and overflow interrupt.
// Assumes pclk is the instruction clock; sleep_mode and ccp_reset come from
// logic on pclk; pin inputs are asynchronous.
//
// How it works
// - 16-bit count in two bytes, wraps
// - Wrap sets overflow flag, bit 0
// - Enable bit 0 gates the interrupt
// - Control bit 1 picks pin or internal
// - Control bit 0 runs or holds count
// - Bits 5-4 divide by 1, 2, 4, 8
// - Oscillator enable forces pins input, reads zero
// - Oscillator enable picks which pin counts
// - Bit 2 set bypasses synchroniser, pin mode
// - Control bits 7-6 read zero
// - Prescaler sits before the synchroniser
// - Synchronised mode stops in sleep, prescaler runs
// - Capture/compare request clears the count
// - Unsynchronised mode counts in sleep, wakes
//
// Local design decision: the APB register port.
module stc_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [stc_pkg::ADDR_W-1:0] paddr,
    input wire logic [stc_pkg::DATA_W-1:0] pwdata,
    output logic [stc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic osc_input_pin,
    input wire logic [1:0] port_direction_bits,
    input wire logic sleep_mode,
    input wire logic ccp_reset,
    output logic irq,
    output logic wake_request,
    output logic [1:0] pin_input_dir,
    output logic [1:0] port_read_zero
);
    stc_ps_if ps_link ();

    logic [1:0] pins_sync;
    logic [stc_pkg::CTRL_W-1:0] ctrl;
    logic [stc_pkg::CTRL_W-1:0] next_ctrl;
    logic [15:0] wide_count;
    logic [15:0] next_wide_count;
    logic overflow_flag;
    logic next_overflow_flag;
    logic overflow_irq_enable;
    logic next_overflow_irq_enable;
    logic [stc_pkg::DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic next_wake_request;
    logic [1:0] next_pin_input_dir;
    logic [1:0] next_port_read_zero;
    logic pin_prev;
    logic next_pin_prev;
    logic sync_tick;
    logic next_sync_tick;
    logic run_control;
    logic clock_source_select;
    logic sync_bypass;
    logic oscillator_enable;
    logic sel_pin;
    logic pin_rise;
    logic count_tick;
    logic wrap;
    logic bus_write;
    logic bus_read;
    logic flag_clear;
    logic wr_low;
    logic wr_high;

    assign run_control = ctrl[stc_pkg::BIT_RUN];
    assign clock_source_select = ctrl[stc_pkg::BIT_CLK_SRC];
    assign sync_bypass = ctrl[stc_pkg::BIT_SYNC_BYPASS];
    assign oscillator_enable = ctrl[stc_pkg::BIT_OSC_EN];

    stc_sync2 #(.WIDTH(2)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({osc_input_pin, external_count_pin}),
        .sync_out(pins_sync)
    );

    stc_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ps(ps_link)
    );

    // ---------------- APB slave ----------------
    assign bus_write = psel && penable && pready && pwrite;
    assign bus_read = psel && penable && !pready && !pwrite;
    assign wr_low = bus_write && (paddr == stc_pkg::OFF_COUNT_LOW);
    assign wr_high = bus_write && (paddr == stc_pkg::OFF_COUNT_HIGH);
    assign flag_clear = bus_write && (paddr == stc_pkg::OFF_FLAG) &&
        !pwdata[stc_pkg::BIT_OVF];

    always_comb begin
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (psel && penable && !pready) begin
            next_prdata = '0;
            case (paddr)
                stc_pkg::OFF_COUNT_LOW: next_prdata[7:0] = wide_count[7:0];
                stc_pkg::OFF_COUNT_HIGH: next_prdata[7:0] = wide_count[15:8];
                stc_pkg::OFF_FLAG: next_prdata[stc_pkg::BIT_OVF] = overflow_flag;
                stc_pkg::OFF_ENABLE: next_prdata[stc_pkg::BIT_OVF] = overflow_irq_enable;
                stc_pkg::OFF_CONTROL: next_prdata[stc_pkg::CTRL_W-1:0] = ctrl;
                default: next_pslverr = 1'b1;
            endcase
            if (!bus_read) begin
                next_prdata = prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ---------------- Control and enable registers ----------------
    always_comb begin
        next_ctrl = ctrl;
        next_overflow_irq_enable = overflow_irq_enable;
        if (bus_write && paddr == stc_pkg::OFF_CONTROL) begin
            next_ctrl = pwdata[stc_pkg::CTRL_W-1:0];
        end
        if (bus_write && paddr == stc_pkg::OFF_ENABLE) begin
            next_overflow_irq_enable = pwdata[stc_pkg::BIT_OVF];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= stc_pkg::CTRL_RST;
            overflow_irq_enable <= 1'b0;
        end else if (ce) begin
            ctrl <= next_ctrl;
            overflow_irq_enable <= next_overflow_irq_enable;
        end
    end

    // ---------------- Input path ----------------
    // Pin edges are seen three cycles late at best; fine for a slow crystal
    assign sel_pin = oscillator_enable ? pins_sync[1] : pins_sync[0];
    assign pin_rise = sel_pin && !pin_prev;

    always_comb begin
        ps_link.ratio = ctrl[stc_pkg::BIT_PS_HI:stc_pkg::BIT_PS_LO];
        // The internal clock stops in sleep; the pin keeps feeding the divider
        ps_link.tick_in = run_control &&
            (clock_source_select ? pin_rise : !sleep_mode);
        next_pin_prev = sel_pin;
        // Synchroniser stage follows the divider and is off in sleep
        next_sync_tick = ps_link.tick_out && !sleep_mode;
        if (!clock_source_select || sync_bypass) begin
            count_tick = ps_link.tick_out;
        end else begin
            count_tick = sync_tick && !sleep_mode;
        end
    end
    // Timer mode ignores the bypass bit since the internal tick is in step

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 1'b0;
            sync_tick <= 1'b0;
        end else if (ce) begin
            pin_prev <= next_pin_prev;
            sync_tick <= next_sync_tick;
        end
    end

    // ---------------- Count and overflow ----------------
    assign wrap = count_tick && run_control && (wide_count == stc_pkg::COUNT_MAX);

    always_comb begin
        next_wide_count = wide_count;
        next_overflow_flag = overflow_flag;
        if (wr_low || wr_high) begin
            // Software write wins over counting; stop the timer first
            if (wr_low) begin
                next_wide_count[7:0] = pwdata[7:0];
            end
            if (wr_high) begin
                next_wide_count[15:8] = pwdata[7:0];
            end
        end else if (ccp_reset) begin
            next_wide_count = stc_pkg::COUNT_RST;
        end else if (count_tick && run_control) begin
            next_wide_count = wide_count + 16'h0001;
        end
        if (flag_clear) begin
            next_overflow_flag = 1'b0;
        end
        if (wrap && !wr_low && !wr_high && !ccp_reset) begin
            next_overflow_flag = 1'b1;
        end
        next_irq = next_overflow_flag && next_overflow_irq_enable;
        next_wake_request = next_irq;
        next_pin_input_dir = next_ctrl[stc_pkg::BIT_OSC_EN] ? 2'h3 : port_direction_bits;
        next_port_read_zero = next_ctrl[stc_pkg::BIT_OSC_EN] ? 2'h3 : 2'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_count <= stc_pkg::COUNT_RST;
            overflow_flag <= 1'b0;
            irq <= 1'b0;
            wake_request <= 1'b0;
            pin_input_dir <= 2'h0;
            port_read_zero <= 2'h0;
        end else if (ce) begin
            wide_count <= next_wide_count;
            overflow_flag <= next_overflow_flag;
            irq <= next_irq;
            wake_request <= next_wake_request;
            pin_input_dir <= next_pin_input_dir;
            port_read_zero <= next_port_read_zero;
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic quiet;
    assign quiet = ce && !wr_low && !wr_high && !ccp_reset;

    // High when the divider's low bit is clear, so a divide-by-two tick must be held back
    logic div_cnt_lsb_zero;
    assign div_cnt_lsb_zero = !u_prescaler.div_cnt[0];

    sequence s_wrap_event;
        quiet && count_tick && run_control && wide_count == 16'hFFFF;
    endsequence

    sequence s_wrapped;
        wide_count == 16'h0000 && overflow_flag;
    endsequence

    a_count_step: assert property (
        quiet && count_tick && run_control |=> wide_count == $past(wide_count) + 16'h0001)
        else $error("count did not step by one");

    a_wrap_flag: assert property (s_wrap_event |=> s_wrapped)
        else $error("wrap did not clear count and set flag");

    a_irq_gate: assert property (
        ce && !flag_clear |=> irq == (overflow_flag && overflow_irq_enable))
        else $error("interrupt not gated by enable");

    a_timer_tick: assert property (
        quiet && run_control && !clock_source_select && !sleep_mode &&
        ctrl[5:4] == 2'h0 |=> wide_count == $past(wide_count) + 16'h0001)
        else $error("timer mode did not count every cycle");

    a_run_hold: assert property (ce && quiet && !run_control |=> $stable(wide_count))
        else $error("count moved while halted");

    a_ratio_two: assert property (
        ps_link.tick_in && ps_link.ratio == 2'h1 && div_cnt_lsb_zero |-> !ps_link.tick_out)
        else $error("divide by two passed an odd tick");

    // Pin outputs follow the control value being loaded, so watch the next one
    a_osc_pins: assert property (
        ce && next_ctrl[stc_pkg::BIT_OSC_EN] |=> pin_input_dir == 2'h3 && port_read_zero == 2'h3)
        else $error("oscillator pins not forced to input");

    a_ctrl_top_zero: assert property (
        pready && psel && !pwrite && paddr == stc_pkg::OFF_CONTROL |-> prdata[7:6] == 2'h0)
        else $error("unimplemented control bits read nonzero");

    a_ccp_clear: assert property (
        ce && ccp_reset && !wr_low && !wr_high |=> wide_count == 16'h0000)
        else $error("capture/compare reset did not clear count");

    a_sleep_hold: assert property (
        quiet && sleep_mode && clock_source_select && !sync_bypass |=> $stable(wide_count))
        else $error("synchronised count moved in sleep");

    a_flag_sticky: assert property (
        ce && overflow_flag && !flag_clear |=> overflow_flag)
        else $error("overflow flag cleared without software");
endmodule

// *** test/stc_pulse_src.sv ***
// Pin clock source standing in for the external clock or the crystal.
// Assumes the pin needs at least two pclk high and two low to be seen.
module stc_pulse_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int phase;
    // Three high, three low: keeps the minimum width with margin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !en) begin
            phase <= 0;
            pin <= 1'h0;
        end else begin
            phase <= (phase == 5) ? 0 : phase + 1;
            pin <= (phase < 3);
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the timer/counter: APB master, two pin sources.
// Assumes one APB wait state and pclk used as the instruction clock.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ext_pin, osc_pin, ext_en, osc_en_src, sleep_mode, ccp_reset, irq, wake_request, er;
    logic [1:0] port_dir, pin_input_dir, port_read_zero;
    logic [15:0] seed;
    int err_total, checked, cyc;

    stc_timer u_stc_timer (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
        .osc_input_pin(osc_pin), .port_direction_bits(port_dir), .sleep_mode(sleep_mode),
        .ccp_reset(ccp_reset), .irq(irq), .wake_request(wake_request),
        .pin_input_dir(pin_input_dir), .port_read_zero(port_read_zero));
    stc_pulse_src u_ext_src (.pclk(pclk), .presetn(presetn), .en(ext_en), .pin(ext_pin));
    stc_pulse_src u_osc_src (.pclk(pclk), .presetn(presetn), .en(osc_en_src), .pin(osc_pin));

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Ticks seen over a window that spans whole periods of the divided input
    function automatic logic [7:0] exp_ticks(input int win, input int per, input int ps,
                                             input bit on);
        return on ? 8'(win / (per << ps)) : 8'h00;
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Waits as long as the slave takes; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk_val(rd, exp);
    endtask
    // Two low-byte reads a whole number of input periods apart
    task automatic rate(input logic [7:0] ctrl, input int per, input int idle, input bit on);
        logic [7:0] a;
        int c1;
        wr(stc_pkg::OFF_CONTROL, {24'h0, ctrl});
        repeat (60) @(posedge pclk);
        apb(1'h0, stc_pkg::OFF_COUNT_LOW, 32'h0);
        a = rd[7:0];
        c1 = cyc;
        repeat (idle) @(posedge pclk);
        apb(1'h0, stc_pkg::OFF_COUNT_LOW, 32'h0);
        chk_val({24'h0, rd[7:0] - a}, {24'h0, exp_ticks(cyc - c1, per, int'(ctrl[5:4]), on)});
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {port_dir, sleep_mode, ccp_reset, ext_en, osc_en_src} = '0;
        err_total = 0;
        checked = 0;
        cyc = 0;
        seed = 16'hCECE;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'(i * 4), 32'h0);
        end
        apb(1'h0, 8'h14, 32'h0);
        chk_val({31'h0, er}, 32'h1);
        wr(stc_pkg::OFF_CONTROL, 32'hC0);
        rd_chk(stc_pkg::OFF_CONTROL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            wr(stc_pkg::OFF_COUNT_LOW, {24'h0, seed[7:0]});
            wr(stc_pkg::OFF_COUNT_HIGH, {24'h0, seed[15:8]});
            rd_chk(stc_pkg::OFF_COUNT_LOW, {24'h0, seed[7:0]});
            rd_chk(stc_pkg::OFF_COUNT_HIGH, {24'h0, seed[15:8]});
        end
        @(posedge pclk);
        ccp_reset <= 1'h1;
        @(posedge pclk);
        ccp_reset <= 1'h0;
        rd_chk(stc_pkg::OFF_COUNT_LOW, 32'h0);
        rd_chk(stc_pkg::OFF_COUNT_HIGH, 32'h0);
        for (int p = 0; p < 4; p++) begin
            rate(8'(p << 4) | 8'h01, 1, 4, 1'h1);
        end
        rate(8'h05, 1, 4, 1'h1);
        rate(8'h00, 1, 4, 1'h0);
        ext_en <= 1'h1;
        for (int p = 0; p < 4; p++) begin
            rate(8'(p << 4) | 8'h03, 6, 44, 1'h1);
        end
        rate(8'h07, 6, 44, 1'h1);
        sleep_mode <= 1'h1;
        rate(8'h03, 6, 44, 1'h0);
        rate(8'h07, 6, 44, 1'h1);
        sleep_mode <= 1'h0;
        rate(8'h0B, 6, 44, 1'h0);
        osc_en_src <= 1'h1;
        ext_en <= 1'h0;
        rate(8'h0B, 6, 44, 1'h1);
        seed = lfsr_next(seed);
        port_dir <= seed[1:0];
        repeat (3) @(posedge pclk);
        chk_pin(pin_input_dir, 2'h3);
        chk_pin(port_read_zero, 2'h3);
        wr(stc_pkg::OFF_CONTROL, 32'h0);
        osc_en_src <= 1'h0;
        repeat (3) @(posedge pclk);
        chk_pin(pin_input_dir, seed[1:0]);
        chk_pin(port_read_zero, 2'h0);
        // Earlier runs may have wrapped; start the wrap check from a clear flag
        wr(stc_pkg::OFF_FLAG, 32'h0);
        rd_chk(stc_pkg::OFF_FLAG, 32'h0);
        wr(stc_pkg::OFF_COUNT_HIGH, 32'hFF);
        wr(stc_pkg::OFF_COUNT_LOW, 32'hF8);
        wr(stc_pkg::OFF_CONTROL, 32'h01);
        repeat (10) @(posedge pclk);
        wr(stc_pkg::OFF_CONTROL, 32'h00);
        rd_chk(stc_pkg::OFF_COUNT_HIGH, 32'h0);
        // Run bit is high for 14 edges: FFF8 plus 14 wraps to 0006
        rd_chk(stc_pkg::OFF_COUNT_LOW, 32'h06);
        rd_chk(stc_pkg::OFF_FLAG, 32'h1);
        chk_val({31'h0, irq}, 32'h0);
        wr(stc_pkg::OFF_ENABLE, 32'h1);
        repeat (2) @(posedge pclk);
        chk_val({31'h0, irq}, 32'h1);
        chk_val({31'h0, wake_request}, 32'h1);
        wr(stc_pkg::OFF_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        chk_val({31'h0, irq}, 32'h0);
        wr(stc_pkg::OFF_FLAG, 32'h1);
        rd_chk(stc_pkg::OFF_FLAG, 32'h1);
        wr(stc_pkg::OFF_FLAG, 32'h0);
        rd_chk(stc_pkg::OFF_FLAG, 32'h0);
        tally_and_finish;
    end
endmodule
